// File: dpg_load_model.sv
`timescale 1ns/1ps
// ==========================================================
// Load on the two pins: times each pulse and drives the mode inputs.
// ==========================================================
module dpg_load_model (
    input wire logic hclk,
    input wire logic pin1,
    input wire logic pin2,
    output logic compare_in1,
    output logic compare_in2,
    output logic stepper_in1
);
    logic [1:0] now;
    logic [1:0] prev = 2'h0;
    int cyc = 0;
    int rises [2] = '{0, 0};
    int rise_at [2] = '{0, 0};
    int per_len [2] = '{0, 0};
    int hi_len [2] = '{0, 0};

    assign now = {pin2, pin1};

    initial begin
        compare_in1 = 1'b0;
        compare_in2 = 1'b0;
        stepper_in1 = 1'b0;
    end

    // Lengths are taken between edges seen at the clock, so one cycle is the finest grain.
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        prev <= now;
        for (int i = 0; i < 2; i++) begin
            if (now[i] && !prev[i]) begin
                rises[i] <= rises[i] + 1;
                rise_at[i] <= cyc;
                per_len[i] <= cyc - rise_at[i];
            end
            if (!now[i] && prev[i]) begin
                hi_len[i] <= cyc - rise_at[i];
            end
        end
    end

    task automatic drive(input logic c1, input logic c2, input logic s1);
        @(posedge hclk);
        compare_in1 <= c1;
        compare_in2 <= c2;
        stepper_in1 <= s1;
    endtask : drive
endmodule : dpg_load_model

// File: dpg_pkg.sv
package dpg_pkg;
    // ==========================================================
    // Register map (byte addresses; no offsets printed, chosen here).
    // ==========================================================
    localparam logic [7:0] DPG_CHAN1_DUTY_LEGACY_OFS = 8'h00;
    localparam logic [7:0] DPG_CHAN2_DUTY_LEGACY_OFS = 8'h04;
    localparam logic [7:0] DPG_SHARED_PRESCALE_LEGACY_OFS = 8'h08;
    localparam logic [7:0] DPG_SHARED_PERIOD_LEGACY_OFS = 8'h0c;
    localparam logic [7:0] DPG_CHAN1_DUTY_OFS = 8'h10;
    localparam logic [7:0] DPG_RESERVED_A_OFS = 8'h14;
    localparam logic [7:0] DPG_CHAN2_DUTY_OFS = 8'h18;
    localparam logic [7:0] DPG_RESERVED_B_OFS = 8'h1c;
    localparam logic [7:0] DPG_CHAN1_PRESCALE_OFS = 8'h20;
    localparam logic [7:0] DPG_CHAN2_PRESCALE_OFS = 8'h24;
    localparam logic [7:0] DPG_CHAN1_PERIOD_OFS = 8'h28;
    localparam logic [7:0] DPG_CHAN2_PERIOD_OFS = 8'h2c;
    localparam logic [7:0] DPG_CONTROL_OFS = 8'h30;
    localparam logic [7:0] DPG_STOP_PRESCALE_OFS = 8'h34;
    localparam logic [7:0] DPG_STOP_PERIOD_OFS = 8'h38;
    localparam logic [7:0] DPG_STOP_DUTY1_OFS = 8'h3c;
    localparam logic [7:0] DPG_STOP_DUTY2_OFS = 8'h40;
    localparam logic [7:0] DPG_STATUS_OFS = 8'h44;

    // ==========================================================
    // Control register fields.
    // ==========================================================
    localparam int DPG_CTL_MODE1_LSB = 0;
    localparam int DPG_CTL_MODE2_LSB = 2;
    localparam int DPG_CTL_OUT1_BIT = 4;
    localparam int DPG_CTL_OUT2_BIT = 5;
    localparam int DPG_CTL_NEWREV_BIT = 6;
    localparam int DPG_CTL_STOP_BIT = 7;
    localparam int DPG_CTL_STOPSUB_BIT = 8;
    localparam int DPG_CTL_EXT1_BIT = 9;
    localparam int DPG_CTL_EXT2_BIT = 10;
    localparam logic [31:0] DPG_CONTROL_RESET = 32'h0000_0000;

    // ==========================================================
    // Source clocks as fractions of the 40 MHz bus clock.
    // ==========================================================
    localparam int DPG_HCLK_HZ = 40_000_000;
    localparam int DPG_SRC_LEGACY_HZ = 16_000_000;
    localparam int DPG_SRC_NEW_HZ = 32_000_000;
    localparam logic [31:0] DPG_ACC_FULL = 32'h0000_0028;
    localparam logic [31:0] DPG_ACC_LEGACY = 32'(DPG_SRC_LEGACY_HZ / 1_000_000);
    localparam logic [31:0] DPG_ACC_NEW = 32'(DPG_SRC_NEW_HZ / 1_000_000);

    typedef enum logic [1:0] {
        DPG_MODE_PLAIN,
        DPG_MODE_PWM,
        DPG_MODE_COMPARE,
        DPG_MODE_STEPPER
    } dpg_mode_t;
endpackage : dpg_pkg

// File: dpg_top.sv
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module dpg_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic compare_in1,
    input wire logic compare_in2,
    input wire logic stepper_in1,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic first_dedicated_output,
    output logic second_dedicated_output
);
    import dpg_pkg::*;

    // ==========================================================
    // Bus slave. Zero wait states; unmapped reads return zero.
    // ==========================================================
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] duty_leg [2];
    logic [31:0] presc_leg;
    logic [31:0] period_leg;
    logic [15:0] duty_new [2];
    logic [15:0] presc_new [2];
    logic [15:0] period_new [2];
    logic [31:0] control;
    logic [31:0] stop_presc;
    logic [31:0] stop_period;
    logic [31:0] stop_duty [2];
    logic [31:0] tick_cnt [2];
    logic [31:0] pwm_cnt [2];
    logic [1:0] pwm_out;
    logic [1:0] armed;
    logic [2:0] cmp_sync [2];
    logic [1:0] cmp_q;
    logic [2:0] stp_sync;
    logic stp_q;
    logic [31:0] next_rdata;

    wire logic addr_ok = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr <= haddr[7:0];
            end
        end
    end

    // Parameter registers are written at any time; the counters pick them up live.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            duty_leg <= '{32'h0, 32'h0};
            presc_leg <= 32'h0;
            period_leg <= 32'h0;
            duty_new <= '{16'h0, 16'h0};
            presc_new <= '{16'h0, 16'h0};
            period_new <= '{16'h0, 16'h0};
            control <= DPG_CONTROL_RESET;
            stop_presc <= 32'h0;
            stop_period <= 32'h0;
            stop_duty <= '{32'h0, 32'h0};
        end else if (wr_pend) begin
            case (wr_addr)
                DPG_CHAN1_DUTY_LEGACY_OFS: duty_leg[0] <= hwdata;
                DPG_CHAN2_DUTY_LEGACY_OFS: duty_leg[1] <= hwdata;
                DPG_SHARED_PRESCALE_LEGACY_OFS: presc_leg <= hwdata;
                DPG_SHARED_PERIOD_LEGACY_OFS: period_leg <= hwdata;
                DPG_CHAN1_DUTY_OFS: duty_new[0] <= hwdata[15:0];
                DPG_CHAN2_DUTY_OFS: duty_new[1] <= hwdata[15:0];
                DPG_CHAN1_PRESCALE_OFS: presc_new[0] <= hwdata[15:0];
                DPG_CHAN2_PRESCALE_OFS: presc_new[1] <= hwdata[15:0];
                DPG_CHAN1_PERIOD_OFS: period_new[0] <= hwdata[15:0];
                DPG_CHAN2_PERIOD_OFS: period_new[1] <= hwdata[15:0];
                DPG_CONTROL_OFS: control <= {21'h0, hwdata[10:0]};
                DPG_STOP_PRESCALE_OFS: stop_presc <= hwdata;
                DPG_STOP_PERIOD_OFS: stop_period <= hwdata;
                DPG_STOP_DUTY1_OFS: stop_duty[0] <= hwdata;
                DPG_STOP_DUTY2_OFS: stop_duty[1] <= hwdata;
                default: begin
                end
            endcase
        end
    end

    // Reserved words read zero and ignore writes.
    always_comb begin
        next_rdata = 32'h0;
        case (haddr[7:0])
            DPG_CHAN1_DUTY_LEGACY_OFS: next_rdata = duty_leg[0];
            DPG_CHAN2_DUTY_LEGACY_OFS: next_rdata = duty_leg[1];
            DPG_SHARED_PRESCALE_LEGACY_OFS: next_rdata = presc_leg;
            DPG_SHARED_PERIOD_LEGACY_OFS: next_rdata = period_leg;
            DPG_CHAN1_DUTY_OFS: next_rdata = {16'h0, duty_new[0]};
            DPG_CHAN2_DUTY_OFS: next_rdata = {16'h0, duty_new[1]};
            DPG_CHAN1_PRESCALE_OFS: next_rdata = {16'h0, presc_new[0]};
            DPG_CHAN2_PRESCALE_OFS: next_rdata = {16'h0, presc_new[1]};
            DPG_CHAN1_PERIOD_OFS: next_rdata = {16'h0, period_new[0]};
            DPG_CHAN2_PERIOD_OFS: next_rdata = {16'h0, period_new[1]};
            DPG_CONTROL_OFS: next_rdata = control;
            DPG_STOP_PRESCALE_OFS: next_rdata = stop_presc;
            DPG_STOP_PERIOD_OFS: next_rdata = stop_period;
            DPG_STOP_DUTY1_OFS: next_rdata = stop_duty[0];
            DPG_STOP_DUTY2_OFS: next_rdata = stop_duty[1];
            DPG_STATUS_OFS: next_rdata = {26'h0, armed, pwm_out, second_dedicated_output, first_dedicated_output};
            default: next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_ok && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    // ==========================================================
    // Modulation engine.
    // ==========================================================
    wire logic new_rev = control[DPG_CTL_NEWREV_BIT];
    wire logic stopped = control[DPG_CTL_STOP_BIT];
    wire logic stop_sub = control[DPG_CTL_STOPSUB_BIT];
    wire logic [1:0] chan_en = {control[DPG_CTL_MODE2_LSB +: 2] == DPG_MODE_PWM,
                                control[DPG_CTL_MODE1_LSB +: 2] == DPG_MODE_PWM};
    // Early revision, whichever channels are enabled: channel 2 reuses channel 1's counter.
    wire logic shared_cnt = !new_rev || (stopped && stop_sub);

    // Selects the counts that govern one channel right now.
    function automatic logic [95:0] chan_params(input int ch);
        logic [31:0] p;
        logic [31:0] per;
        logic [31:0] dty;
        p = new_rev ? {16'h0, presc_new[ch]} : presc_leg;
        per = new_rev ? {16'h0, period_new[ch]} : period_leg;
        dty = new_rev ? {16'h0, duty_new[ch]} : duty_leg[ch];
        if (stopped && stop_sub) begin
            p = stop_presc;
            per = stop_period;
            dty = stop_duty[ch];
        end
        return {p, per, dty};
    endfunction : chan_params

    // The source clock is made by a fractional accumulator, so ticks jitter by one hclk
    // against an exact 16 or 32 MHz grid; the mean rate is exact.
    logic [31:0] frac_acc [2];
    logic [1:0] src_tick;
    wire logic [31:0] src_step = new_rev ? DPG_ACC_NEW : DPG_ACC_LEGACY;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frac_acc <= '{32'h0, 32'h0};
            src_tick <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (frac_acc[c] + src_step >= DPG_ACC_FULL) begin
                    frac_acc[c] <= frac_acc[c] + src_step - DPG_ACC_FULL;
                    src_tick[c] <= 1'b1;
                end else begin
                    frac_acc[c] <= frac_acc[c] + src_step;
                    src_tick[c] <= 1'b0;
                end
            end
        end
    end

    // Prescale divides the source tick, then the period counter wraps.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt <= '{32'h0, 32'h0};
            pwm_cnt <= '{32'h0, 32'h0};
        end else begin
            for (int c = 0; c < 2; c++) begin
                logic [95:0] cp;
                cp = chan_params(c);
                if (src_tick[c]) begin
                    if (tick_cnt[c] >= cp[95:64]) begin
                        tick_cnt[c] <= 32'h0;
                        if (pwm_cnt[c] + 32'h1 >= cp[63:32]) begin
                            pwm_cnt[c] <= 32'h0;
                        end else begin
                            pwm_cnt[c] <= pwm_cnt[c] + 32'h1;
                        end
                    end else begin
                        tick_cnt[c] <= tick_cnt[c] + 32'h1;
                    end
                end
            end
        end
    end

    // Output stays low until period and duty are both nonzero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_out <= 2'b00;
            armed <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                logic [95:0] cp;
                logic [31:0] cnt;
                cp = chan_params(c);
                cnt = (shared_cnt && !new_rev) ? pwm_cnt[0] : pwm_cnt[c];
                armed[c] <= (cp[63:32] != 32'h0) && (cp[31:0] != 32'h0);
                if (stopped && !stop_sub) begin
                    pwm_out[c] <= pwm_out[c];
                end else if (!chan_en[c] || cp[63:32] == 32'h0 || cp[31:0] == 32'h0) begin
                    pwm_out[c] <= 1'b0;
                end else begin
                    pwm_out[c] <= cnt < cp[31:0];
                end
            end
        end
    end

    // ==========================================================
    // Outside mode sources pass four flip-flops; the fourth loads only when the second and third agree.
    // ==========================================================
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_sync <= '{3'h0, 3'h0};
            cmp_q <= 2'b00;
            stp_sync <= 3'h0;
            stp_q <= 1'b0;
        end else begin
            cmp_sync[0] <= {cmp_sync[0][1:0], compare_in1};
            cmp_sync[1] <= {cmp_sync[1][1:0], compare_in2};
            stp_sync <= {stp_sync[1:0], stepper_in1};
            for (int c = 0; c < 2; c++) begin
                if (cmp_sync[c][2] == cmp_sync[c][1]) begin
                    cmp_q[c] <= cmp_sync[c][2];
                end
            end
            if (stp_sync[2] == stp_sync[1]) begin
                stp_q <= stp_sync[2];
            end
        end
    end

    // ==========================================================
    // Output mode selection.
    // ==========================================================
    function automatic logic mode_mux(input logic [1:0] m, input logic reg_bit, input logic pwm_bit,
                                      input logic cmp_bit, input logic stp_bit);
        case (dpg_mode_t'(m))
            DPG_MODE_PLAIN: return reg_bit;
            DPG_MODE_PWM: return pwm_bit;
            DPG_MODE_COMPARE: return cmp_bit;
            DPG_MODE_STEPPER: return stp_bit;
            default: return 1'b0;
        endcase
    endfunction : mode_mux

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_dedicated_output <= 1'b0;
            second_dedicated_output <= 1'b0;
        end else begin
            first_dedicated_output <= mode_mux(control[DPG_CTL_MODE1_LSB +: 2], control[DPG_CTL_OUT1_BIT],
                                               pwm_out[0], cmp_q[0], stp_q);
            second_dedicated_output <= mode_mux(control[DPG_CTL_MODE2_LSB +: 2], control[DPG_CTL_OUT2_BIT],
                                                pwm_out[1], cmp_q[1], 1'b0);
        end
    end

    // ==========================================================
    // Checks.
    // ==========================================================
    // Every pin is registered, so each check except stop_hold_a and ready_ok_a looks one cycle after the state that causes it.
    plain_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (control[1:0] == 2'b00) && $stable(control) |=> first_dedicated_output == $past(control[DPG_CTL_OUT1_BIT]))
        else $error("plain output does not follow register bit");
    zero_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !stopped && !new_rev && period_leg == 32'h0 |=> !pwm_out[0])
        else $error("modulation high with zero period");
    stop_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        stopped && stop_sub && stop_duty[1] == 32'h0 |=> !pwm_out[1])
        else $error("stop output high with zero duty");
    stop_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        stopped && !stop_sub && $past(stopped && !stop_sub) |-> $stable(pwm_out))
        else $error("held stop state changed");
    wrap_count_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !new_rev && !stopped && period_leg != 32'h0 && $stable(period_leg) && pwm_cnt[0] < period_leg
        |=> pwm_cnt[0] < period_leg)
        else $error("counter passed period");
    duty_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !stopped && chan_en[0] && armed[0] && !new_rev && pwm_cnt[0] < duty_leg[0] && $stable(duty_leg[0])
        |=> pwm_out[0])
        else $error("output low below duty");
    shared_edge_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !new_rev && !stopped && chan_en == 2'b11 && period_leg != 32'h0 && duty_leg[0] != 32'h0
        && duty_leg[1] != 32'h0 && pwm_cnt[0] == 32'h0
        |=> pwm_out == 2'b11)
        else $error("channels misaligned");
    plain_second_a: assert property (@(posedge hclk) disable iff (!hresetn)
        control[DPG_CTL_MODE2_LSB +: 2] == 2'b00 |=> second_dedicated_output == $past(control[DPG_CTL_OUT2_BIT]))
        else $error("second plain output does not follow register bit");
    stop_period_a: assert property (@(posedge hclk) disable iff (!hresetn)
        stopped && stop_sub && stop_period == 32'h0 |=> pwm_out == 2'b00)
        else $error("stop output high with zero period");
    ready_ok_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("bus not ready");
    pwm_run_c: cover property (@(posedge hclk) disable iff (!hresetn) $rose(first_dedicated_output));
    stop_sub_c: cover property (@(posedge hclk) disable iff (!hresetn) stopped && stop_sub && pwm_out[1]);
    new_rev_c: cover property (@(posedge hclk) disable iff (!hresetn) new_rev && pwm_out == 2'b11);
    hold_c: cover property (@(posedge hclk) disable iff (!hresetn) stopped && !stop_sub);
    compare_c: cover property (@(posedge hclk) disable iff (!hresetn)
        control[1:0] == 2'b10 && first_dedicated_output);
endmodule : dpg_top

// File: dpg_top_test.sv
`timescale 1ns/1ps
module dpg_top_test;
    import dpg_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic compare_in1;
    logic compare_in2;
    logic stepper_in1;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic pin1;
    logic pin2;
    logic [31:0] pins;
    logic [31:0] rd;
    logic [31:0] lv;
    int n;
    int errors = 0;
    int total_checks = 0;

    // The single slave's ready is the bus's ready.
    assign hready = hreadyout;
    assign pins = {30'h0, pin2, pin1};

    initial begin
        forever #12.5 hclk = ~hclk;
    end

    dpg_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .compare_in1(compare_in1),
        .compare_in2(compare_in2), .stepper_in1(stepper_in1), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .first_dedicated_output(pin1), .second_dedicated_output(pin2));

    dpg_load_model load (.hclk(hclk), .pin1(pin1), .pin2(pin2), .compare_in1(compare_in1),
        .compare_in2(compare_in2), .stepper_in1(stepper_in1));

    // ==========================================================
    // Checking and bus tasks.
    // ==========================================================
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // High times jitter by a cycle because the source clock is a fraction of the bus clock.
    function automatic logic [31:0] near(input int seen, input int exp);
        return (seen >= exp - 2 && seen <= exp + 2) ? 32'(exp) : 32'(seen);
    endfunction : near

    task automatic cycles(input int c);
        repeat (c) @(posedge hclk);
    endtask : cycles

    task automatic wait_ready;
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (hreadyout !== 1'b1) begin
            errors++;
            stop_test();
        end
    endtask : wait_ready

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(name, rd, exp);
        chk("okay response", 32'(hresp), 32'h0);
    endtask : rd_chk

    task automatic wait_rises(input int i, input int c);
        int b;
        int k;
        b = load.rises[i];
        k = 0;
        while (load.rises[i] < b + c && k < 5000) begin
            @(posedge hclk);
            k++;
        end
        if (k >= 5000) begin
            errors++;
            stop_test();
        end
        @(posedge hclk);
    endtask : wait_rises

    // ==========================================================
    // Scenarios.
    // ==========================================================
    initial begin
        repeat (16) @(posedge hclk);
        chk("pins in reset", pins, 32'h0);
        hresetn <= 1'b1;
        for (int a = 0; a <= 8'h48; a += 4) begin
            rd_chk("reset value", 8'(a), 32'h0);
        end
        wr(DPG_CHAN1_DUTY_LEGACY_OFS, 32'hdead_beef);
        rd_chk("legacy word", DPG_CHAN1_DUTY_LEGACY_OFS, 32'hdead_beef);
        wr(DPG_CHAN1_DUTY_OFS, 32'h1234_5678);
        rd_chk("short word", DPG_CHAN1_DUTY_OFS, 32'h0000_5678);
        wr(DPG_RESERVED_A_OFS, 32'hffff_ffff);
        rd_chk("reserved a", DPG_RESERVED_A_OFS, 32'h0);
        wr(DPG_RESERVED_B_OFS, 32'hffff_ffff);
        rd_chk("reserved b", DPG_RESERVED_B_OFS, 32'h0);
        wr(8'h48, 32'hffff_ffff);
        rd_chk("unmapped", 8'h48, 32'h0);
        wr(DPG_CHAN1_DUTY_OFS, 32'h0);
        for (int v = 0; v < 4; v++) begin
            wr(DPG_CONTROL_OFS, 32'(v) << 4);
            cycles(4);
            chk("plain pins", pins, 32'(v));
        end
        load.drive(1'b1, 1'b0, 1'b0);
        wr(DPG_CONTROL_OFS, 32'h0000_000a);
        cycles(12);
        chk("compare pins", pins, 32'h1);
        load.drive(1'b0, 1'b1, 1'b0);
        cycles(12);
        chk("compare pins", pins, 32'h2);
        wr(DPG_CONTROL_OFS, 32'h0000_000f);
        load.drive(1'b0, 1'b1, 1'b1);
        cycles(12);
        chk("stepper pins", pins, 32'h1);
        load.drive(1'b0, 1'b0, 1'b0);
        // Duty set but period still zero: both pins must stay quiet.
        wr(DPG_CHAN1_DUTY_LEGACY_OFS, 32'd3);
        wr(DPG_CHAN2_DUTY_LEGACY_OFS, 32'd7);
        wr(DPG_SHARED_PRESCALE_LEGACY_OFS, 32'd1);
        wr(DPG_CONTROL_OFS, 32'h0000_0005);
        n = load.rises[0] + load.rises[1];
        cycles(100);
        chk("unarmed pins", pins, 32'h0);
        chk("unarmed rises", 32'(load.rises[0] + load.rises[1]), 32'(n));
        wr(DPG_SHARED_PERIOD_LEGACY_OFS, 32'd10);
        wait_rises(0, 3);
        chk("old period 1", 32'(load.per_len[0]), 32'd50);
        chk("old period 2", 32'(load.per_len[1]), 32'd50);
        chk("old high 1", near(load.hi_len[0], 15), 32'd15);
        chk("old high 2", near(load.hi_len[1], 35), 32'd35);
        chk("aligned edges", 32'(load.rise_at[0] - load.rise_at[1]), 32'h0);
        wr(DPG_CHAN1_DUTY_LEGACY_OFS, 32'd5);
        wait_rises(0, 3);
        chk("new high 1", near(load.hi_len[0], 25), 32'd25);
        chk("kept high 2", near(load.hi_len[1], 35), 32'd35);
        wr(DPG_CONTROL_OFS, 32'h0000_0021);
        cycles(4);
        chk("lone channel", 32'(pin2), 32'h1);
        wait_rises(0, 2);
        chk("lone period", 32'(load.per_len[0]), 32'd50);
        wr(DPG_CHAN1_PRESCALE_OFS, 32'd1);
        wr(DPG_CHAN1_PERIOD_OFS, 32'd8);
        wr(DPG_CHAN1_DUTY_OFS, 32'd2);
        wr(DPG_CHAN2_PRESCALE_OFS, 32'd3);
        wr(DPG_CHAN2_PERIOD_OFS, 32'd8);
        wr(DPG_CHAN2_DUTY_OFS, 32'd4);
        wr(DPG_CONTROL_OFS, 32'h0000_0045);
        wait_rises(1, 3);
        chk("rev period 1", 32'(load.per_len[0]), 32'd20);
        chk("rev period 2", 32'(load.per_len[1]), 32'd40);
        chk("rev high 1", near(load.hi_len[0], 5), 32'd5);
        chk("rev high 2", near(load.hi_len[1], 20), 32'd20);
        wr(DPG_CONTROL_OFS, 32'h0000_00c5);
        cycles(4);
        lv = pins;
        n = load.rises[0] + load.rises[1];
        cycles(200);
        chk("hold level", pins, lv);
        chk("hold rises", 32'(load.rises[0] + load.rises[1]), 32'(n));
        rd_chk("hold status", DPG_STATUS_OFS, 32'h30 | (lv << 2) | lv);
        wr(DPG_STOP_DUTY1_OFS, 32'd2);
        wr(DPG_CONTROL_OFS, 32'h0000_01c5);
        wr(DPG_STOP_DUTY2_OFS, 32'd2);
        cycles(4);
        n = load.rises[0] + load.rises[1];
        cycles(200);
        chk("stop low", pins, 32'h0);
        chk("stop rises", 32'(load.rises[0] + load.rises[1]), 32'(n));
        wr(DPG_STOP_PERIOD_OFS, 32'd4);
        wait_rises(0, 3);
        wait_rises(1, 1);
        chk("stop shared", 32'(load.per_len[0] - load.per_len[1]), 32'h0);
        stop_test();
    end
endmodule : dpg_top_test
